// file: include/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
  // register offsets
  localparam logic [7:0] MISC_CFG_ADDR = 8'h17;
  localparam logic [7:0] PROBE_TRIG_ADDR = 8'h18;
  // reset values
  localparam logic [7:0] MISC_CFG_RESET = 8'h80;
  localparam logic [7:0] PROBE_TRIG_RESET = 8'h00;
  // configuration field positions
  localparam int IRQ_OFF_BIT = 7;
  localparam int CAP_OFF_BIT = 6;
  localparam int GRADED_PRIO_BIT = 4;
  localparam int CLASS_ON_CHANGE_BIT = 3;
  localparam int PROBE_ON_CHANGE_BIT = 2;
  // writable configuration bits, others read as zero
  localparam logic [7:0] MISC_CFG_MASK = 8'hdc;
  // probe trigger layout: classify bits high nibble, probe bits low
  localparam int CLASS_LSB = 4;
  localparam int PROBE_LSB = 0;
  localparam int NUM_PORTS = 4;
  // port operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_HOST_ASSISTED = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // register write/read request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmc_req_t;

  // one result update from a port state machine
  typedef struct packed {
    logic valid;
    logic [3:0] value;
  } pmc_result_t;
endpackage : pmc_pkg
`default_nettype wire

// file: src/pmc_misc_probe.sv
// What this block does
// - interrupt pin driven only when bit7 clear
// - bit6 clear enables capacitance measurement
// - bit4 selects graded versus single priority
// - bit3 set: classify event only on change
// - bit2 set: probe event only on change
// - trigger high nibble classify, low probe
// - pair 01 probe, 11 probe plus classify
// - host-assisted and auto modes copy bits into enables
// - config read/write; trigger write-only, resets zero
`default_nettype none
module pmc_misc_probe
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register access
  input wire pmc_req_t req,
  output logic [7:0] rdata_q,
  // port state machine side
  input wire logic [NUM_PORTS*2-1:0] port_op_mode,
  input wire logic [NUM_PORTS-1:0] probe_started,
  input wire pmc_result_t [NUM_PORTS-1:0] port_classify_result,
  input wire pmc_result_t [NUM_PORTS-1:0] port_probe_result,
  input wire logic irq_pending,
  // configuration, commands and done events
  output logic cap_measure_off,
  output logic graded_priority_sel,
  output logic [NUM_PORTS-1:0] run_probe_q,
  output logic [NUM_PORTS-1:0] run_classify_q,
  output logic [NUM_PORTS-1:0] probe_enable_q,
  output logic [NUM_PORTS-1:0] classify_enable_q,
  output logic [NUM_PORTS-1:0] classify_finish_evt,
  output logic [NUM_PORTS-1:0] probe_finish_evt,
  // interrupt pin, open drain
  output logic irq_out_n,
  output logic irq_oe_n
);

  // ==========================================================
  // configuration register
  // requests come from the serial front end on core_clk as one
  // cycle strobes, so the decode below needs no synchroniser
  logic [7:0] misc_cfg_q;
  logic wr_cfg;
  logic wr_trig;
  // address decode of the two write strobes; writes to any other
  // offset change nothing in this block
  assign wr_cfg = req.wr && (req.addr == MISC_CFG_ADDR);
  assign wr_trig = req.wr && (req.addr == PROBE_TRIG_ADDR);

  // host writable configuration; reserved bits 5, 1 and 0 are
  // stored as zero so that a read-back never shows stale values
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      misc_cfg_q <= MISC_CFG_RESET;
    end else if (wr_cfg) begin
      misc_cfg_q <= req.wdata & MISC_CFG_MASK;
    end
  end

  // read data; the trigger register is write-only and reads as
  // zero, as does every unmapped offset
  // rdata_q holds until the next read strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == MISC_CFG_ADDR) begin
        rdata_q <= misc_cfg_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // configuration outputs registered; they follow the register one
  // cycle late, which the port machines tolerate since these bits
  // are only consulted at the start of a detection or a shutdown
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cap_measure_off <= MISC_CFG_RESET[CAP_OFF_BIT];
      graded_priority_sel <= MISC_CFG_RESET[GRADED_PRIO_BIT];
    end else begin
      cap_measure_off <= misc_cfg_q[CAP_OFF_BIT];
      graded_priority_sel <= misc_cfg_q[GRADED_PRIO_BIT];
    end
  end

  // ==========================================================
  // interrupt pin drive: low when pending and drive enabled
  // the pin is open drain: the value is always low and only the
  // enable moves, so the line is never driven high against other
  // devices sharing its pull-up
  // bit 7 resets to 1, keeping the pin released until the host
  // has set up its handler
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_out_n <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      irq_out_n <= 1'b0;
      irq_oe_n <= !(irq_pending && !misc_cfg_q[IRQ_OFF_BIT]);
    end
  end

  // ==========================================================
  // probe trigger decoding per port
  logic [NUM_PORTS-1:0] trig_cls;
  logic [NUM_PORTS-1:0] trig_det;
  logic [NUM_PORTS-1:0] is_manual;
  logic [NUM_PORTS-1:0] is_copy_mode;
  // trigger fields, classify bits above probe bits
  assign trig_cls = req.wdata[CLASS_LSB +: NUM_PORTS];
  assign trig_det = req.wdata[PROBE_LSB +: NUM_PORTS];

  // per-port mode decode; off mode matches neither vector, so a
  // trigger written to a port that is off is dropped
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      is_manual[i] = (port_op_mode[i*2 +: 2] == MODE_MANUAL);
      is_copy_mode[i] = (port_op_mode[i*2 +: 2] == MODE_HOST_ASSISTED) ||
        (port_op_mode[i*2 +: 2] == MODE_AUTO);
    end
  end

  // one-shot requests, held until the port starts the probe
  // a write in the same cycle as the start wins, so a fresh command
  // issued just as the previous one is taken up is never lost
  // pair 10 carries no probe bit and falls through here unused
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      run_probe_q <= PROBE_TRIG_RESET[PROBE_LSB +: NUM_PORTS];
      run_classify_q <= PROBE_TRIG_RESET[CLASS_LSB +: NUM_PORTS];
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (wr_trig && is_manual[i] && trig_det[i]) begin
          // 01 probe only, 11 probe and classify; 10 ignored
          run_probe_q[i] <= 1'b1;
          run_classify_q[i] <= trig_cls[i];
        end else if (probe_started[i]) begin
          run_probe_q[i] <= 1'b0;
          run_classify_q[i] <= 1'b0;
        end
      end
    end
  end

  // host-assisted and auto modes: written pair becomes the enable bits
  // the enables hold until the next trigger write in one of these modes; they are not
  // one-shot, since the automatic machine reads them on every pass
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      probe_enable_q <= '0;
      classify_enable_q <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (wr_trig && is_copy_mode[i]) begin
          probe_enable_q[i] <= trig_det[i];
          classify_enable_q[i] <= trig_cls[i];
        end
      end
    end
  end

  // ==========================================================
  // result tracking and done events
  // last-value registers reset to zero, so in on-change mode a
  // first result of zero raises no event
  // an update and its event sit one cycle apart; the port machine
  // may post a new result every cycle
  logic [NUM_PORTS-1:0][3:0] cls_last_q;
  logic [NUM_PORTS-1:0][3:0] det_last_q;

  // last classification result, compared on the next update
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cls_last_q <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (port_classify_result[i].valid) begin
          cls_last_q[i] <= port_classify_result[i].value;
        end
      end
    end
  end

  // last probe result, compared on the next update
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      det_last_q <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (port_probe_result[i].valid) begin
          det_last_q[i] <= port_probe_result[i].value;
        end
      end
    end
  end

  // done events: one-cycle pulses, on every update or on change only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      classify_finish_evt <= '0;
      probe_finish_evt <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        classify_finish_evt[i] <= port_classify_result[i].valid &&
          (!misc_cfg_q[CLASS_ON_CHANGE_BIT] ||
           port_classify_result[i].value != cls_last_q[i]);
        probe_finish_evt[i] <= port_probe_result[i].valid &&
          (!misc_cfg_q[PROBE_ON_CHANGE_BIT] ||
           port_probe_result[i].value != det_last_q[i]);
      end
    end
  end

endmodule : pmc_misc_probe
`default_nettype wire

// file: testbench/pmc_host.sv
`default_nettype none
module pmc_host
  import pmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] rdata_q,
  output var pmc_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // write, trigger pair code 10 never sent
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, a, (a == PROBE_TRIG_ADDR) ?
      {d[7:4] & d[3:0], d[3:0]} : d};
    @(posedge core_clk);
    req <= '0;
  endtask : wr
  // read, data taken once the answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge core_clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    req <= '0;
    #1 q = rdata_q;
  endtask : rd
endmodule : pmc_host
`default_nettype wire

// file: testbench/pmc_misc_probe_asserts.sv
`default_nettype none
module pmc_asserts
  import pmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire pmc_req_t req,
  input wire logic [7:0] rdata_q,
  input wire logic [7:0] port_op_mode,
  input wire logic irq_pending,
  input wire logic cap_measure_off,
  input wire logic graded_priority_sel,
  input wire logic [3:0] run_probe_q,
  input wire logic [3:0] run_classify_q,
  input wire logic [3:0] classify_finish_evt,
  input wire logic [3:0] probe_finish_evt,
  input wire pmc_result_t [3:0] port_classify_result,
  input wire pmc_result_t [3:0] port_probe_result,
  input wire logic irq_out_n,
  input wire logic irq_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // strobes of the two mapped writes
  wire cfg_wr = req.wr && req.addr == MISC_CFG_ADDR;
  wire trg_wr = req.wr && req.addr == PROBE_TRIG_ADDR;
  a_irq_drive: assert property (
    !irq_oe_n |-> !irq_out_n && $past(irq_pending)) else $error("bad irq");
  a_cap_follow: assert property (cfg_wr |-> ##2
    cap_measure_off == $past(req.wdata[6], 2)) else $error("bad cap");
  a_prio_follow: assert property (cfg_wr |-> ##2
    graded_priority_sel == $past(req.wdata[4], 2)) else $error("bad prio");
  a_trig_unread: assert property (
    req.rd && req.addr == PROBE_TRIG_ADDR |=> rdata_q == 8'h00)
    else $error("bad trig read");
  a_class_cause: assert property (
    classify_finish_evt[0] |-> $past(port_classify_result[0].valid))
    else $error("bad class evt");
  a_probe_cause: assert property (
    probe_finish_evt[0] |-> $past(port_probe_result[0].valid))
    else $error("bad probe evt");
  a_pair_legal: assert property (run_classify_q[0] |-> run_probe_q[0])
    else $error("bad pair");
  a_trig_manual: assert property (trg_wr && req.wdata[0] &&
    port_op_mode[1:0] == MODE_MANUAL |=> run_probe_q[0] &&
    run_classify_q[0] == $past(req.wdata[4])) else $error("bad run");
  c_cfg: cover property (cfg_wr);
  c_run: cover property (run_probe_q[0]);
  c_evt: cover property (classify_finish_evt[0]);
endmodule : pmc_asserts
`default_nettype wire

// file: testbench/tb_pmc_misc_probe.sv
`default_nettype none
module tb_pmc_misc_probe
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  wire pmc_req_t req;
  logic [7:0] rdata_q, q;
  logic [7:0] port_op_mode = 8'h55;
  logic [3:0] probe_started = 4'h0;
  logic [3:0] run_probe_q, run_classify_q, probe_enable_q;
  logic [3:0] classify_enable_q, classify_finish_evt, probe_finish_evt;
  pmc_result_t [3:0] port_classify_result = '0;
  pmc_result_t [3:0] port_probe_result = '0;
  logic irq_pending = 1'b0;
  logic cap_measure_off, graded_priority_sel, irq_out_n, irq_oe_n;
  int err_total = 0;
  int samples_checked = 0;
  pmc_misc_probe pmc_misc_probe_inst (
    .core_clk(core_clk),
    .resetn(resetn),
    .req(req),
    .rdata_q(rdata_q),
    .port_op_mode(port_op_mode),
    .probe_started(probe_started),
    .port_classify_result(port_classify_result),
    .port_probe_result(port_probe_result),
    .irq_pending(irq_pending),
    .cap_measure_off(cap_measure_off),
    .graded_priority_sel(graded_priority_sel),
    .run_probe_q(run_probe_q),
    .run_classify_q(run_classify_q),
    .probe_enable_q(probe_enable_q),
    .classify_enable_q(classify_enable_q),
    .classify_finish_evt(classify_finish_evt),
    .probe_finish_evt(probe_finish_evt),
    .irq_out_n(irq_out_n),
    .irq_oe_n(irq_oe_n)
  );
  pmc_host pmc_host_inst (
    .core_clk(core_clk),
    .rdata_q(rdata_q),
    .req(req)
  );
  always #10 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic t_cfg;
    chk({run_classify_q, run_probe_q}, 8'h00);
    pmc_host_inst.rd(MISC_CFG_ADDR, q);
    chk(q, MISC_CFG_RESET);
    pmc_host_inst.wr(MISC_CFG_ADDR, 8'hff);
    pmc_host_inst.rd(PROBE_TRIG_ADDR, q);
    chk(q, 8'h00);
    chk({4'h0, cap_measure_off, graded_priority_sel, irq_oe_n,
      irq_out_n}, 8'h0e);
    pmc_host_inst.rd(MISC_CFG_ADDR, q);
    chk(q, 8'hdc);
    pmc_host_inst.wr(MISC_CFG_ADDR, 8'h00);
    pmc_host_inst.rd(8'h20, q);
    chk(q, 8'h00);
    chk({4'h0, cap_measure_off, graded_priority_sel, irq_oe_n,
      irq_out_n}, 8'h00);
  endtask : t_cfg
  task automatic t_trig;
    pmc_host_inst.wr(PROBE_TRIG_ADDR, 8'h13);
    #1 chk({run_classify_q, run_probe_q}, 8'h13);
    @(posedge core_clk) probe_started <= 4'hf;
    @(posedge core_clk) probe_started <= 4'h0;
    #1 chk({run_classify_q, run_probe_q}, 8'h00);
    @(posedge core_clk) port_op_mode <= 8'haf;
    pmc_host_inst.wr(PROBE_TRIG_ADDR, 8'h13);
    #1 chk({classify_enable_q, probe_enable_q}, 8'h13);
    // ports off: a trigger write changes neither enables nor commands
    @(posedge core_clk) port_op_mode <= 8'h00;
    pmc_host_inst.wr(PROBE_TRIG_ADDR, 8'hff);
    #1 chk({classify_enable_q, probe_enable_q}, 8'h13);
    chk({run_classify_q, run_probe_q}, 8'h00);
  endtask : t_trig
  // one result update on port 0, then the events seen
  task automatic pulse(input logic [3:0] v, input logic [7:0] e);
    @(posedge core_clk);
    port_classify_result[0] <= {1'b1, v};
    port_probe_result[0] <= {1'b1, v};
    @(posedge core_clk);
    port_classify_result <= '0;
    port_probe_result <= '0;
    #1 chk({classify_finish_evt, probe_finish_evt}, e);
  endtask : pulse
  task automatic t_evt;
    pulse(4'h5, 8'h11);
    pulse(4'h5, 8'h11);
    pmc_host_inst.wr(MISC_CFG_ADDR, 8'h0c);
    pulse(4'h5, 8'h00);
    pulse(4'h9, 8'h11);
  endtask : t_evt
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    irq_pending <= 1'b1;
    t_cfg();
    t_trig();
    t_evt();
    end_of_test();
  end
  // watchdog
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule : tb_pmc_misc_probe
bind pmc_misc_probe pmc_asserts pmc_asserts_inst (
  .core_clk(core_clk),
  .resetn(resetn),
  .req(req),
  .rdata_q(rdata_q),
  .port_op_mode(port_op_mode),
  .irq_pending(irq_pending),
  .cap_measure_off(cap_measure_off),
  .graded_priority_sel(graded_priority_sel),
  .run_probe_q(run_probe_q),
  .run_classify_q(run_classify_q),
  .classify_finish_evt(classify_finish_evt),
  .probe_finish_evt(probe_finish_evt),
  .port_classify_result(port_classify_result),
  .port_probe_result(port_probe_result),
  .irq_out_n(irq_out_n),
  .irq_oe_n(irq_oe_n)
);
`default_nettype wire
